// File: olc_pkg.sv
// Package of the overcurrent sense configuration and fault block.
// Assumes a 10 MHz pclk and an APB register slave with 32-bit data.
package olc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int OLC_CLK_NS       = 100;  // Period of pclk
  localparam int OLC_BLANK_LS_NS  = 672;  // Low-side switch blanking
  localparam int OLC_BLANK_DCR_NS = 352;  // Winding resistance blanking
  // Least times, rounded up to whole cycles
  localparam logic [7:0] OLC_BLANK_LS_CYC  = 8'((OLC_BLANK_LS_NS + OLC_CLK_NS - 1) / OLC_CLK_NS);
  localparam logic [7:0] OLC_BLANK_DCR_CYC = 8'((OLC_BLANK_DCR_NS + OLC_CLK_NS - 1) / OLC_CLK_NS);
  localparam logic [3:0] OLC_VIOL_ALLOWED  = 4'h5;  // Violations tolerated

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OLC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] OLC_STATUS_OFS = 12'h004;
  localparam logic [11:0] OLC_ISTAT_OFS  = 12'h008;
  localparam logic [11:0] OLC_IMASK_OFS  = 12'h00C;

  // ==========================================================
  // Field positions
  localparam int OLC_ST_METHOD = 0;  // Status: method in use, 2 bits
  localparam int OLC_ST_FAULT  = 2;  // Status: latched fault flag
  localparam int OLC_ST_COUNT  = 3;  // Status: violation count, 4 bits
  localparam int OLC_ST_RES    = 7;  // Status: method strap holds resistor
  localparam int OLC_ST_LIMIT  = 8;  // Status: limit strap resistor found
  localparam int OLC_IRQ_FAULT = 0;  // Event: fault declared
  localparam int OLC_IRQ_VIOL  = 1;  // Event: violating cycle
  localparam int OLC_IRQ_W     = 2;  // Event bits

  // ==========================================================
  // Sensing methods
  typedef logic [1:0] olc_method_t;
  localparam olc_method_t OLC_M_LS = 2'h0;  // Low-side switch on-resistance
  localparam olc_method_t OLC_M_DN = 2'h1;  // Winding resistance, down-slope
  localparam olc_method_t OLC_M_UP = 2'h2;  // Winding resistance, up-slope

  // Level seen on the sense method strap
  typedef logic [1:0] olc_strap_t;
  localparam olc_strap_t OLC_S_LOW  = 2'h0;
  localparam olc_strap_t OLC_S_OPEN = 2'h1;
  localparam olc_strap_t OLC_S_HIGH = 2'h2;
  localparam olc_strap_t OLC_S_RES  = 2'h3;

  // ==========================================================
  // Control register layout
  typedef struct packed {
    logic              shutdown;    // Fault action: 1 turns drive off
    logic [7:0]        blank;       // Blanking cycles when cfg_en
    logic [3:0]        limit;       // Violations allowed when cfg_en
    logic              cfg_en;      // Use software count and blanking
    olc_method_t       ovr_method;  // Method chosen by software
    logic              ovr_en;      // Software method overrides straps
  } olc_ctrl_s;
  localparam logic [16:0] OLC_CTRL_RST = 17'h10750;

  // Strap inputs travel together
  typedef struct packed {
    logic              limit_present;  // Finite resistor on limit strap
    olc_strap_t        level;          // Sense method strap level
    olc_method_t       res_method;     // Method from resistor decode
  } olc_strap_s;

endpackage

// File: olc_down_timer.sv
// Loadable down counter for the blanking interval.
// Assumes load is a one-cycle pulse in pclk domain.
`timescale 1ns/1ns
`default_nettype none
module olc_down_timer #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic      [W-1:0] cnt,
  output logic              expired
);
  // ==========================================================
  // Count down to zero, reload on request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign expired = (cnt == '0);  // Blanking over
endmodule
`default_nettype wire

// File: olc_viol_counter.sv
// Saturating counter of consecutive violating cycles.
// Assumes inc and clr never fire together.
`timescale 1ns/1ns
`default_nettype none
module olc_viol_counter #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         inc,
  input  wire logic         clr,
  output logic      [W-1:0] cnt
);
  // ==========================================================
  // Clear on a clean cycle, count up on a bad one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (inc && cnt != '1) begin
      cnt <= cnt + W'(1);
    end
  end
endmodule
`default_nettype wire

// File: olc_top.sv
// Overcurrent sense configuration, blanking and fault logic.
// Assumes straps, gate level and comparator are synchronous to pclk.
//
// Contract
// (RULE1) Low strap: low-side sensing, 672ns blanking
// (RULE2) Open strap: down-slope winding sensing, 352ns
// (RULE3) High strap: up-slope winding sensing, 352ns
// (RULE4) Tolerate five violations before fault response
// (RULE5) No limit resistor: default to low-side sensing
// (RULE6) Board fits 10 to 100 kilohm limit resistor
// (RULE7) Resistor on method strap: separate decode
// (RULE8) Software may override the strapped method
// (RULE9) Count, blanking and action are configurable
// (RULE10) Evaluate only within chosen switching interval
// (RULE11) Mask during blanking, clean cycle clears count
// (RULE12) Exceeded count latches readable fault, acts
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module olc_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire olc_pkg::olc_strap_s strap,
  input  wire logic                hs_gate,
  input  wire logic                comp_over,
  output logic                     fault_shutdown,
  output logic                     fault_flag,
  output olc_pkg::olc_method_t     method_out,
  output logic                     irq
);
  import olc_pkg::*;

  // ==========================================================
  // Evaluation states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,  // Waiting for window start
    ST_BLANK = 3'b010,  // Comparator masked
    ST_EVAL  = 3'b100   // Comparator watched
  } olc_state_e;

  olc_state_e             state;       // Evaluation state
  olc_state_e             next_state;  // Its next value
  olc_ctrl_s              ctrl;        // Control register
  olc_strap_s             strap_q;     // Straps caught after reset
  logic                   strap_taken; // Straps caught once
  logic [OLC_IRQ_W-1:0]   istat;       // Sticky events
  logic [OLC_IRQ_W-1:0]   imask;       // Event mask
  logic                   win_q;       // Window level, last cycle
  logic                   viol_seen;   // Violation in this window
  logic [7:0]             blank_cnt;   // Blanking cycles left
  logic                   blank_done;  // Blanking over
  logic [3:0]             viol_cnt;    // Consecutive bad cycles

  // ==========================================================
  // Strap capture after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q     <= '0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_q     <= strap;
      strap_taken <= 1'b1;
    end
  end

  // ==========================================================
  // Method selection
  wire strap_is_res = (strap_q.level == OLC_S_RES);
  // Decode is only valid with a limit resistor fitted [RULE6]
  wire olc_method_t lvl_method =
      (strap_q.level == OLC_S_LOW)  ? OLC_M_LS :  // [RULE1]
      (strap_q.level == OLC_S_OPEN) ? OLC_M_DN :  // [RULE2]
      (strap_q.level == OLC_S_HIGH) ? OLC_M_UP :  // [RULE3]
      strap_q.res_method;                         // [RULE7]
  // Missing limit resistor forces low-side sensing [RULE5]
  wire olc_method_t strap_method = strap_q.limit_present ? lvl_method : OLC_M_LS;
  // Software choice takes over when enabled [RULE8]
  wire olc_method_t raw_method = ctrl.ovr_en ? ctrl.ovr_method : strap_method;
  // Undefined code falls back to low-side sensing
  wire olc_method_t method = (raw_method == 2'h3) ? OLC_M_LS : raw_method;

  // ==========================================================
  // Blanking and count limits
  wire [7:0] meth_blank = (method == OLC_M_LS) ? OLC_BLANK_LS_CYC : OLC_BLANK_DCR_CYC;  // [RULE1] [RULE2] [RULE3]
  wire [7:0] blank_sel  = ctrl.cfg_en ? ctrl.blank : meth_blank;        // [RULE9]
  wire [3:0] limit_sel  = ctrl.cfg_en ? ctrl.limit : OLC_VIOL_ALLOWED;  // [RULE4] [RULE9]

  // ==========================================================
  // Sensing window decode
  // Up-slope watches the high-side on time, others the low-side
  wire win       = (method == OLC_M_UP) ? hs_gate : !hs_gate;  // [RULE10]
  wire win_start = win && !win_q;
  wire in_idle   = (state == ST_IDLE);
  wire in_blank  = (state == ST_BLANK);
  wire in_eval   = (state == ST_EVAL);
  wire tmr_load  = in_idle && win_start;
  wire cyc_end   = in_eval && !win;
  wire bad_end   = cyc_end && viol_seen;
  wire clean_end = cyc_end && !viol_seen;  // [RULE11]
  // Count would pass the allowance on this bad cycle
  wire fault_hit = bad_end && (viol_cnt >= limit_sel);  // [RULE4] [RULE12]

  // Window level history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= 1'b0;
    end else begin
      win_q <= win;
    end
  end

  // ==========================================================
  // Evaluation sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // Window opens: start blanking
        if (win_start) begin
          next_state = ST_BLANK;
        end
      end
      ST_BLANK: begin
        // Window shut inside blanking: no verdict
        if (!win) begin
          next_state = ST_IDLE;
        end else if (blank_done) begin
          next_state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        // Window shut: cycle verdict taken
        if (!win) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Comparator looked at only past blanking, inside window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_seen <= 1'b0;
    end else if (in_idle) begin
      viol_seen <= 1'b0;
    end else if (in_eval && win && comp_over) begin
      viol_seen <= 1'b1;  // [RULE10] [RULE11]
    end
  end

  // ==========================================================
  // Blanking timer and violation counter
  olc_down_timer #(
    .W       (8)
  ) u_blank (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tmr_load),
    .value   (blank_sel),
    .cnt     (blank_cnt),
    .expired (blank_done)
  );

  olc_viol_counter #(
    .W       (4)
  ) u_viol (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (bad_end),
    .clr     (clean_end),
    .cnt     (viol_cnt)
  );

  // ==========================================================
  // APB decode
  wire acc      = psel && penable && pready;
  wire wr       = acc && pwrite;
  wire hit_ctrl = (paddr == OLC_CTRL_OFS);
  wire hit_stat = (paddr == OLC_STATUS_OFS);
  wire hit_ist  = (paddr == OLC_ISTAT_OFS);
  wire hit_imk  = (paddr == OLC_IMASK_OFS);
  wire hit_any  = hit_ctrl || hit_stat || hit_ist || hit_imk;
  wire clr_flt  = wr && hit_stat && pwdata[OLC_ST_FAULT];
  wire [OLC_IRQ_W-1:0] ist_clr = (wr && hit_ist) ? pwdata[OLC_IRQ_W-1:0] : '0;
  wire [OLC_IRQ_W-1:0] ist_set = {bad_end, fault_hit};
  wire [31:0] stat_word = {23'h0, strap_q.limit_present, strap_is_res, viol_cnt, fault_flag, method};
  wire [31:0] rd_data =
      hit_ctrl ? {15'h0, ctrl} :
      hit_stat ? stat_word :
      hit_ist  ? {30'h0, istat} :
      hit_imk  ? {30'h0, imask} :
      32'h0;

  // One wait state, answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_data;
      pslverr <= psel && penable && !pready && !hit_any;
    end
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= olc_ctrl_s'(OLC_CTRL_RST);
      imask <= '0;
    end else if (wr && hit_ctrl) begin
      ctrl  <= olc_ctrl_s'(pwdata[16:0]);  // [RULE8] [RULE9]
    end else if (wr && hit_imk) begin
      imask <= pwdata[OLC_IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Fault flag, events and outputs
  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag <= 1'b0;
      istat      <= '0;
    end else begin
      fault_flag <= fault_hit || (fault_flag && !clr_flt);  // [RULE12]
      istat      <= ist_set | (istat & ~ist_clr);
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_shutdown <= 1'b0;
      method_out     <= OLC_M_LS;
      irq            <= 1'b0;
    end else begin
      fault_shutdown <= ctrl.shutdown && (fault_hit || (fault_flag && !clr_flt));  // [RULE9] [RULE12]
      method_out     <= method;
      irq            <= |((ist_set | (istat & ~ist_clr)) & imask);  // Only unmasked events
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_open_ls;
    in_idle && win_start && !ctrl.cfg_en && method == OLC_M_LS;
  endsequence

  sequence s_open_dcr;
    in_idle && win_start && !ctrl.cfg_en && method != OLC_M_LS;
  endsequence

  sequence s_last_bad;
    bad_end && viol_cnt == limit_sel;
  endsequence

  chk_blank_low_side: assert property (s_open_ls |=> blank_cnt == 8'h07 && in_blank)  // [RULE1]
    else $error("low-side blanking not seven cycles");
  chk_blank_down: assert property (s_open_dcr |=> blank_cnt == 8'h04)  // [RULE2]
    else $error("winding blanking not four cycles");
  chk_up_window: assert property ((in_eval && method == OLC_M_UP && win) |-> hs_gate)  // [RULE3]
    else $error("up-slope evaluated outside high-side time");
  chk_fault_limit: assert property (s_last_bad |=> fault_flag ##1 istat[OLC_IRQ_FAULT])  // [RULE4]
    else $error("fault not declared past allowance");
  chk_no_early_fault: assert property (  // [RULE4]
      (bad_end && viol_cnt < limit_sel && !fault_flag && !clr_flt) |=> !$rose(fault_flag))
    else $error("fault declared before allowance reached");
  chk_no_limit_res: assert property ((!strap_q.limit_present && !ctrl.ovr_en) |-> method == OLC_M_LS)  // [RULE5]
    else $error("missing limit resistor not defaulted");
  chk_res_decode: assert property (  // [RULE7]
      (strap_q.limit_present && strap_is_res && !ctrl.ovr_en && strap_q.res_method != 2'h3)
      |-> method == strap_q.res_method)
    else $error("resistor decode not applied");
  chk_override: assert property (  // [RULE8]
      (ctrl.ovr_en && ctrl.ovr_method != 2'h3) |=> method_out == $past(ctrl.ovr_method))
    else $error("software method not applied");
  chk_blank_mask: assert property ((in_blank && comp_over) |=> !$rose(viol_seen))  // [RULE11]
    else $error("comparator seen during blanking");
  chk_clean_clear: assert property (clean_end |=> viol_cnt == 4'h0)  // [RULE11]
    else $error("clean cycle did not clear count");
  chk_eval_only: assert property ($rose(viol_seen) |-> $past(in_eval) && $past(win))  // [RULE10]
    else $error("violation taken outside evaluation");
  chk_shutdown_act: assert property ((fault_hit && ctrl.shutdown) |=> fault_shutdown [*2])  // [RULE12] [RULE9]
    else $error("fault action not carried out");
  chk_apb_answer: assert property ((psel && penable && !pready) |=> pready)
    else $error("register access not answered");

endmodule
`default_nettype wire

// File: olc_strap_net.sv
// Model of the board straps, switch node and current comparator.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
`default_nettype none
module olc_strap_net (
  input  wire logic           pclk,
  output var olc_pkg::olc_strap_s strap,
  output var logic            hs_gate,
  output var logic            comp_over
);
  import olc_pkg::*;

  // ==========================================================
  // Power-up state: limit resistor fitted, switch idle
  initial begin
    strap     = '{1'b1, OLC_S_LOW, OLC_M_LS};
    hs_gate   = 1'b1;
    comp_over = 1'b0;
  end

  // Fit straps; a present limit resistor lies in range
  task automatic set(input logic lp, input olc_strap_t lv, input olc_method_t rm, input logic up);
    strap     <= '{lp, lv, rm};
    hs_gate   <= ~up;
    comp_over <= 1'b0;
  endtask

  // ==========================================================
  // One period: 14 cycles of window, 6 outside, comparator hit at one cycle
  task automatic period(input logic up, input int hit);
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      hs_gate   <= (i < 14) ? up : ~up;
      comp_over <= (i == hit);
    end
  endtask
endmodule
`default_nettype wire

// File: overcurrent_sense_config_fault_bench.sv
// Self-checking bench of the overcurrent sense configuration block.
// Assumes olc_pkg, the design and the strap network model compiled first.
`timescale 1ns/1ns
`default_nettype none
module overcurrent_sense_config_fault_bench;
  import olc_pkg::*;

  typedef struct packed {
    logic        port;  // Port probe instead of bus answer
    logic [32:0] exp;   // Expected error bit and data
    logic [32:0] mask;  // Bits compared
  } olc_note_s;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        probe   = 1'b0;  // Asks the monitor to compare ports
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] seed    = 32'h094938AE;
  logic [31:0] prdata;
  logic [31:0] st;
  logic        pready;
  logic        pslverr;
  logic        hs_gate;
  logic        comp_over;
  logic        fault_shutdown;
  logic        fault_flag;
  logic        irq;
  logic        up;
  logic [32:0] got;
  olc_strap_s  strap;
  olc_method_t method_out;
  olc_ctrl_s   ctrl;
  olc_note_s   nt;
  olc_note_s   notes[$];
  int          fail_count  = 0;
  int          check_count = 0;
  olc_strap_t  cl[5] = '{OLC_S_LOW, OLC_S_OPEN, OLC_S_HIGH, OLC_S_RES, OLC_S_HIGH};
  logic        cp[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  olc_method_t cm[5] = '{OLC_M_LS, OLC_M_DN, OLC_M_UP, OLC_M_DN, OLC_M_LS};

  // ==========================================================
  // Clock and instances
  always #50 pclk = ~pclk;

  olc_top olc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap(strap),
    .hs_gate(hs_gate), .comp_over(comp_over), .fault_shutdown(fault_shutdown), .fault_flag(fault_flag),
    .method_out(method_out), .irq(irq));

  olc_strap_net olc_strap_net_i (.pclk(pclk), .strap(strap), .hs_gate(hs_gate), .comp_over(comp_over));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One bus transfer; the expectation is noted first
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    int n;
    notes.push_back('{1'b0, e, m});
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("Error pready expected 1 seen %b", pready);
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, checking only the error bit
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h100000000);
  endtask

  // Read, checking error bit and masked data
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  // Port probe of shutdown, flag, irq and method
  task automatic look(input logic [4:0] e);
    notes.push_back('{1'b1, 33'(e), 33'h1F});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  // Reset with straps fitted and switch idle
  task automatic boot(input olc_strap_t lv, input logic lp, input logic u, input int n);
    @(posedge pclk);
    presetn <= 1'b0;
    olc_strap_net_i.set(lp, lv, OLC_M_DN, u);
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // ==========================================================
  // Monitor: oldest note against each result
  always @(posedge pclk) begin
    if ((psel & penable & pready) === 1'b1 || probe === 1'b1) begin
      nt  = notes.pop_front();
      got = nt.port ? 33'({fault_shutdown, fault_flag, irq, method_out}) : {pslverr, prdata};
      check_count++;
      if ((got & nt.mask) !== (nt.exp & nt.mask)) begin
        fail_count++;
        $display("Error %s %h expected %h seen %h", nt.port ? "ports" : "bus", paddr, nt.exp & nt.mask,
                 got & nt.mask);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    $display("Error run length expected end seen none");
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    boot(OLC_S_LOW, 1'b1, 1'b0, 20);
    rd(OLC_CTRL_OFS, 32'h00010750, 32'hFFFFFFFF);
    seed = xorshift(seed);
    // Unmapped word: error answer, read data zero
    apb(1'b1, 12'h010, seed, 33'h100000000, 33'h100000000);
    apb(1'b0, 12'h010, 32'h0, 33'h100000000, 33'h1FFFFFFFF);
    rd(OLC_CTRL_OFS, 32'h00010750, 32'hFFFFFFFF);
    for (int k = 0; k < 5; k++) begin
      up = (cm[k] == OLC_M_UP);
      boot(cl[k], cp[k], up, 4);
      st = {23'h0, cp[k], cl[k] == OLC_S_RES, 4'h0, 1'b0, cm[k]};
      look({3'h0, cm[k]});
      rd(OLC_STATUS_OFS, st, 32'h1FF);
      olc_strap_net_i.period(up, 7);
      rd(OLC_STATUS_OFS, st | ((cm[k] == OLC_M_LS) ? 32'h0 : 32'h8), 32'h1FF);
      olc_strap_net_i.period(up, 17);
      rd(OLC_STATUS_OFS, st, 32'h1FF);
      repeat (5) olc_strap_net_i.period(up, 11);
      look({3'h0, cm[k]});
      olc_strap_net_i.period(up, 11);
      look({3'b110, cm[k]});
    end
    rd(OLC_ISTAT_OFS, 32'h1, 32'h1);
    wr(OLC_IMASK_OFS, 32'h1);
    look({3'b111, OLC_M_LS});
    wr(OLC_ISTAT_OFS, 32'h3);
    wr(OLC_STATUS_OFS, 32'h4);
    look({3'b000, OLC_M_LS});
    seed = xorshift(seed);
    wr(OLC_IMASK_OFS, seed);
    rd(OLC_IMASK_OFS, seed & 32'h3, 32'hFFFFFFFF);
    boot(OLC_S_LOW, 1'b1, 1'b1, 4);
    ctrl = '{1'b1, 8'h03, 4'h2, 1'b1, OLC_M_UP, 1'b1};
    wr(OLC_CTRL_OFS, 32'(ctrl));
    look({3'h0, OLC_M_UP});
    repeat (2) olc_strap_net_i.period(1'b1, 11);
    look({3'h0, OLC_M_UP});
    olc_strap_net_i.period(1'b1, 11);
    look({3'b110, OLC_M_UP});
    test_done();
  end
endmodule
`default_nettype wire
